// *** pssci_pkg.sv ***
package pssci_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_MOD = 3;
  localparam int CMP_W   = 12;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 6;
  localparam int NUM_CMP = 4;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CNF       = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_ROUTE     = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_TRIGSEL   = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_IMASK     = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_IFLAG     = 6'h05;
  localparam logic [ADDR_W-1:0] OFS_ICTL_BASE = 6'h06;
  localparam logic [ADDR_W-1:0] OFS_CMP_BASE  = 6'h10;
  localparam int                CMP_STRIDE    = 8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_CCYC   = 1;
  localparam int CTRL_CLKSEL = 5;
  localparam int CTRL_PRE_LO = 6;
  localparam int CNF_POLA    = 2;
  localparam int CNF_POLB    = 3;
  localparam int CNF_MODE    = 4;
  localparam int CNF_LOCK    = 5;
  localparam int ICTL_LVL_HI = 0;
  localparam int ICTL_EDGE   = 1;
  localparam int ICTL_FAULT  = 2;
  localparam int IF_EV_LSB   = 0;
  localparam int IF_END_LSB  = 3;
  localparam int ROUTE_W     = 6;
  localparam int TRIG_W      = 2;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [DATA_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_MASK  = 8'hE3;
  localparam logic [DATA_W-1:0] CNF_MASK   = 8'h3C;
  localparam logic [DATA_W-1:0] ICTL_MASK  = 8'h07;
  localparam logic [DATA_W-1:0] REG_RST    = 8'h00;
  localparam logic [CMP_W-1:0]  CMP_RST    = 12'h000;
  localparam logic [DATA_W-1:0] TC_DIV4    = 8'h03;
  localparam logic [DATA_W-1:0] TC_DIV32   = 8'h1F;
  localparam logic [DATA_W-1:0] TC_DIV256  = 8'hFF;
  localparam logic [DATA_W-1:0] TC_DIV1    = 8'h00;

  typedef enum logic [1:0] {
    PRE_1   = 2'b00,
    PRE_4   = 2'b01,
    PRE_32  = 2'b10,
    PRE_256 = 2'b11
  } pssci_pre_e;

  typedef enum logic [1:0] {
    TRIG_A_LEAD  = 2'b00,
    TRIG_A_TRAIL = 2'b01,
    TRIG_B_LEAD  = 2'b10,
    TRIG_B_TRAIL = 2'b11
  } pssci_trig_e;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } pssci_dir_e;

  // one module's active compare set
  typedef struct packed {
    logic [CMP_W-1:0] sa;
    logic [CMP_W-1:0] ra;
    logic [CMP_W-1:0] sb;
    logic [CMP_W-1:0] rb;
  } pssci_cmp_s;

endpackage

// *** pssci_top.sv ***
`timescale 1ns/1ns
// Summary of operation
// - each module makes its own adc trigger
// - each module has separate interrupt outputs
// - sources: reload, input event, sync error
// - input event on active edge or level onset
// - clock select 0 io clock, 1 pll clock
// - prescaler codes divide by 1, 4, 32, 256
// - end of cycle on reset compare b match
// - fault interrupt on input event, own vector
// - per-module registers replicated for three modules
// - routing bits 5..0 pick waveform or port
// - enabled pin follows its module waveform
// - trigger select two bits per module
// - one-ramp codes pick a/b leading or trailing
// - trailing trigger also on fault on part
// - centre codes 00 down, 01 up reset-a match
// - centre codes 10 and 11 give no trigger
// - compares twelve bits, two bytes, reset zero
// - update lock holds routing and compares
// - high byte to temp, low byte commits
module pssci_top
  import pssci_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_pll_clk,
  input  wire logic [NUM_MOD-1:0] i_fault_in,
  input  wire logic [NUM_MOD-1:0] i_sync_error,
  input  wire logic [ROUTE_W-1:0] i_port_out,
  output logic      [ROUTE_W-1:0] o_pin_out,
  output logic      [NUM_MOD-1:0] o_adc_trigger,
  output logic      [NUM_MOD-1:0] o_end_of_cycle_irq,
  output logic      [NUM_MOD-1:0] o_fault_event_irq,
  output logic                    o_divided_controller_clock
);

  // ****************************************************************
  // software registers
  // ****************************************************************
  logic [DATA_W-1:0]  ctrl_q;
  logic [DATA_W-1:0]  cnf_q;
  logic [ROUTE_W-1:0] route_sh_q;
  logic [ROUTE_W-1:0] route_q;
  logic [DATA_W-1:0]  trigsel_q;
  logic [DATA_W-1:0]  imask_q;
  logic [DATA_W-1:0]  iflag_q;
  logic [DATA_W-1:0]  iflag_d;
  logic [DATA_W-1:0]  temp_q;
  logic [DATA_W-1:0]  ictl_q [NUM_MOD];
  logic [CMP_W-1:0]   sh_q   [NUM_MOD*NUM_CMP];
  logic [CMP_W-1:0]   act_q  [NUM_MOD*NUM_CMP];
  logic [DATA_W-1:0]  rdata_d;
  logic [DATA_W-1:0]  cmp_rd [NUM_MOD*NUM_CMP*2];

  // shared per-module status
  logic [NUM_MOD-1:0] eoc;
  logic [NUM_MOD-1:0] in_event;
  logic [NUM_MOD-1:0] upd_ok;
  logic [NUM_MOD-1:0] trig_d;
  logic [NUM_MOD-1:0] wave_a;
  logic [NUM_MOD-1:0] wave_b;
  logic [NUM_MOD-1:0] running;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire logic wr_ctrl    = i_wr && (i_addr == OFS_CTRL);
  wire logic wr_cnf     = i_wr && (i_addr == OFS_CNF);
  wire logic wr_route   = i_wr && (i_addr == OFS_ROUTE);
  wire logic wr_trigsel = i_wr && (i_addr == OFS_TRIGSEL);
  wire logic wr_imask   = i_wr && (i_addr == OFS_IMASK);
  wire logic wr_iflag   = i_wr && (i_addr == OFS_IFLAG);
  wire logic lock       = cnf_q[CNF_LOCK];
  wire logic centre     = cnf_q[CNF_MODE];
  wire logic run_bit    = ctrl_q[CTRL_RUN];

  // control registers; run bit starts the counters
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q    <= CTRL_RST;
      cnf_q     <= REG_RST;
      trigsel_q <= REG_RST;
      imask_q   <= REG_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= i_wdata & CTRL_MASK;
      if (wr_cnf) cnf_q <= i_wdata & CNF_MASK;
      if (wr_trigsel) trigsel_q <= i_wdata;
      if (wr_imask) imask_q <= i_wdata;
    end
  end

  // routing goes through a shadow so a lock can hold it
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      route_sh_q <= REG_RST[ROUTE_W-1:0];
      route_q    <= REG_RST[ROUTE_W-1:0];
    end else begin
      if (wr_route) route_sh_q <= i_wdata[ROUTE_W-1:0];
      if (upd_ok[0]) route_q <= route_sh_q;
    end
  end

  // ****************************************************************
  // compare registers behind the shared high-byte holder
  // ****************************************************************
  wire logic cmp_hi_wr = i_wr && !i_addr[0] && (i_addr >= OFS_CMP_BASE) &&
    (i_addr < OFS_CMP_BASE + ADDR_W'(NUM_MOD * CMP_STRIDE));

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      temp_q <= REG_RST;
    end else if (cmp_hi_wr) begin
      temp_q <= i_wdata;
    end
  end

  for (genvar e = 0; e < NUM_MOD*NUM_CMP; e++) begin : g_cmp
    localparam logic [ADDR_W-1:0] A_HI =
      OFS_CMP_BASE + ADDR_W'((e / NUM_CMP) * CMP_STRIDE + (e % NUM_CMP) * 2);
    localparam logic [ADDR_W-1:0] A_LO = A_HI + 6'h01;
    wire logic lo_wr = i_wr && (i_addr == A_LO);

    // low byte write commits both bytes at once, so no torn value
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        sh_q[e]  <= CMP_RST;
        act_q[e] <= CMP_RST;
      end else begin
        if (lo_wr) sh_q[e] <= {temp_q[3:0], i_wdata};
        if (upd_ok[e / NUM_CMP]) act_q[e] <= sh_q[e];
      end
    end

    assign cmp_rd[2*e]   = {4'h0, sh_q[e][CMP_W-1:DATA_W]};
    assign cmp_rd[2*e+1] = sh_q[e][DATA_W-1:0];
  end

  // ****************************************************************
  // controller clock: select and prescale
  // ****************************************************************
  logic       pll_s1_q;
  logic       pll_s2_q;
  logic       pll_s3_q;
  logic       pll_lvl_q;
  logic       clksel_q;
  logic [1:0] pre_q;
  logic [7:0] pre_cnt_q;
  logic       div_tick_q;

  // three-stage sampling of the pll clock pin
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pll_s1_q  <= 1'b0;
      pll_s2_q  <= 1'b0;
      pll_s3_q  <= 1'b0;
      pll_lvl_q <= 1'b0;
    end else begin
      pll_s1_q <= i_pll_clk;
      pll_s2_q <= pll_s1_q;
      pll_s3_q <= pll_s2_q;
      if (pll_s2_q == pll_s3_q) pll_lvl_q <= pll_s2_q;
    end
  end

  wire logic pll_rise = (pll_s2_q == pll_s3_q) && pll_s2_q && !pll_lvl_q;
  wire logic src_tick = clksel_q ? pll_rise : 1'b1;

  logic [7:0] pre_tc;
  always_comb begin
    unique case (pssci_pre_e'(pre_q))
      PRE_1:   pre_tc = TC_DIV1;
      PRE_4:   pre_tc = TC_DIV4;
      PRE_32:  pre_tc = TC_DIV32;
      PRE_256: pre_tc = TC_DIV256;
    endcase
  end

  wire logic div_end = src_tick && (pre_cnt_q == pre_tc);

  // new source and divider only taken at a period end, no runt pulse
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clksel_q   <= 1'b0;
      pre_q      <= 2'b00;
      pre_cnt_q  <= 8'h00;
      div_tick_q <= 1'b0;
    end else begin
      div_tick_q <= div_end;
      if (div_end) begin
        pre_cnt_q <= 8'h00;
        clksel_q  <= ctrl_q[CTRL_CLKSEL];
        pre_q     <= ctrl_q[CTRL_PRE_LO+1:CTRL_PRE_LO];
      end else if (src_tick) begin
        pre_cnt_q <= pre_cnt_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // per-module counter, waveform, input and trigger
  // ****************************************************************
  for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
    pssci_cmp_s       cm;
    logic [CMP_W-1:0] cnt_q;
    pssci_dir_e       dir_q;
    logic             run_q;
    logic             a_q;
    logic             b_q;
    logic             s1_q;
    logic             s2_q;
    logic             s3_q;
    logic             filt_q;
    logic             act_prev_q;
    logic [1:0]       code;

    assign cm = {act_q[m*NUM_CMP], act_q[m*NUM_CMP+1],
                 act_q[m*NUM_CMP+2], act_q[m*NUM_CMP+3]};
    assign code = trigsel_q[m*TRIG_W +: TRIG_W];

    wire logic tick     = div_tick_q && run_q;
    wire logic m_sa     = tick && (cnt_q == cm.sa);
    wire logic m_ra     = tick && (cnt_q == cm.ra);
    wire logic m_sb     = tick && (cnt_q == cm.sb);
    wire logic m_rb     = tick && (cnt_q == cm.rb);
    wire logic going_up = (dir_q == DIR_UP);
    wire logic in_act   = (filt_q == ictl_q[m][ICTL_LVL_HI]);

    // fault input: three flops, change taken when last two agree
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        s1_q       <= 1'b0;
        s2_q       <= 1'b0;
        s3_q       <= 1'b0;
        filt_q     <= 1'b0;
        act_prev_q <= 1'b1; // no false event right after reset
      end else begin
        s1_q <= i_fault_in[m];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) filt_q <= s2_q;
        act_prev_q <= in_act;
      end
    end

    // edge mode: active edge; level mode: onset of the level
    assign in_event[m] = in_act && !act_prev_q;
    wire logic fault_on = ictl_q[m][ICTL_FAULT] &&
                          (ictl_q[m][ICTL_EDGE] ? in_event[m] : in_act);

    // counter: one-ramp wraps at rb, centre turns round at rb
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        cnt_q <= CMP_RST;
        dir_q <= DIR_UP;
      end else if (!run_q) begin
        cnt_q <= CMP_RST;
        dir_q <= DIR_UP;
      end else if (div_tick_q) begin
        if (!centre) begin
          cnt_q <= m_rb ? CMP_RST : cnt_q + 12'h001;
          dir_q <= DIR_UP;
        end else begin
          unique case (dir_q)
            DIR_UP: begin
              if (m_rb) begin
                dir_q <= DIR_DOWN;
                cnt_q <= (cnt_q == CMP_RST) ? cnt_q : cnt_q - 12'h001;
              end else begin
                cnt_q <= cnt_q + 12'h001;
              end
            end
            DIR_DOWN: begin
              if (cnt_q == CMP_RST) begin
                dir_q <= DIR_UP;
                cnt_q <= cnt_q + 12'h001;
              end else begin
                cnt_q <= cnt_q - 12'h001;
              end
            end
          endcase
        end
      end
    end

    assign eoc[m] = m_rb;
    assign upd_ok[m] = !lock && (eoc[m] || !run_q);
    assign running[m] = run_q;

    // complete-cycle bit lets the counter finish before halting
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        run_q <= 1'b0;
      end else if (run_bit) begin
        run_q <= 1'b1;
      end else if (!ctrl_q[CTRL_CCYC] || eoc[m]) begin
        run_q <= 1'b0;
      end
    end

    // waveform parts; fault forces both parts inactive
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        a_q <= 1'b0;
        b_q <= 1'b0;
      end else if (!run_q || fault_on) begin
        a_q <= 1'b0;
        b_q <= 1'b0;
      end else if (!centre) begin
        if (m_ra) a_q <= 1'b0;
        else if (m_sa) a_q <= 1'b1;
        if (m_rb) b_q <= 1'b0;
        else if (m_sb) b_q <= 1'b1;
      end else begin
        if (m_sa) a_q <= going_up;
        if (m_sb) b_q <= !going_up;
      end
    end

    assign wave_a[m] = cnf_q[CNF_POLA] ? a_q : !a_q;
    assign wave_b[m] = cnf_q[CNF_POLB] ? b_q : !b_q;

    wire logic trail_a = m_ra || (fault_on && a_q);
    wire logic trail_b = m_rb || (fault_on && b_q);

    // trigger source; in centre mode only reset-a matches count
    always_comb begin
      if (!centre) begin
        unique case (pssci_trig_e'(code))
          TRIG_A_LEAD:  trig_d[m] = m_sa;
          TRIG_A_TRAIL: trig_d[m] = trail_a;
          TRIG_B_LEAD:  trig_d[m] = m_sb;
          TRIG_B_TRAIL: trig_d[m] = trail_b;
        endcase
      end else begin
        unique case (pssci_trig_e'(code))
          TRIG_A_LEAD:  trig_d[m] = m_ra && !going_up;
          TRIG_A_TRAIL: trig_d[m] = m_ra && going_up;
          TRIG_B_LEAD:  trig_d[m] = 1'b0;
          TRIG_B_TRAIL: trig_d[m] = 1'b0;
        endcase
      end
    end

    // input control, one per module
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ictl_q[m] <= REG_RST;
      end else if (i_wr && (i_addr == OFS_ICTL_BASE + ADDR_W'(m))) begin
        ictl_q[m] <= i_wdata & ICTL_MASK;
      end
    end
  end

  // ****************************************************************
  // interrupt flags: set wins over write-one-to-clear
  // ****************************************************************
  wire logic [NUM_MOD-1:0] ev_set = in_event | i_sync_error;

  always_comb begin
    iflag_d = iflag_q & ~(wr_iflag ? i_wdata : REG_RST);
    iflag_d[IF_EV_LSB +: NUM_MOD]  = iflag_d[IF_EV_LSB +: NUM_MOD] | ev_set;
    iflag_d[IF_END_LSB +: NUM_MOD] = iflag_d[IF_END_LSB +: NUM_MOD] | eoc;
  end

  wire logic [DATA_W-1:0] irq_pend = iflag_q & imask_q;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      iflag_q <= REG_RST;
    end else begin
      iflag_q <= iflag_d;
    end
  end

  // ****************************************************************
  // read mux and registered outputs
  // ****************************************************************
  // compare bytes sit in address order, so the offset is the index
  wire logic [ADDR_W-1:0] cmp_idx = i_addr - OFS_CMP_BASE;

  always_comb begin
    rdata_d = REG_RST;
    if (i_addr >= OFS_CMP_BASE) begin
      if (cmp_idx < ADDR_W'(NUM_MOD * CMP_STRIDE)) begin
        rdata_d = cmp_rd[cmp_idx[4:0]];
      end
    end else if (i_addr == OFS_CTRL) begin
      rdata_d = ctrl_q;
    end else if (i_addr == OFS_CNF) begin
      rdata_d = cnf_q;
    end else if (i_addr == OFS_ROUTE) begin
      rdata_d = {2'b00, route_sh_q};
    end else if (i_addr == OFS_TRIGSEL) begin
      rdata_d = trigsel_q;
    end else if (i_addr == OFS_IMASK) begin
      rdata_d = imask_q;
    end else if (i_addr == OFS_IFLAG) begin
      rdata_d = iflag_q;
    end else if (i_addr < OFS_ICTL_BASE + ADDR_W'(NUM_MOD)) begin
      rdata_d = ictl_q[2'(i_addr - OFS_ICTL_BASE)];
    end
  end

  // pins mux waveform or port logic; unenabled pins pass port value
  logic [ROUTE_W-1:0] pin_d;
  for (genvar p = 0; p < NUM_MOD; p++) begin : g_pin
    assign pin_d[2*p]   = route_q[2*p]   ? wave_a[p] : i_port_out[2*p];
    assign pin_d[2*p+1] = route_q[2*p+1] ? wave_b[p] : i_port_out[2*p+1];
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata                    <= REG_RST;
      o_pin_out                  <= REG_RST[ROUTE_W-1:0];
      o_adc_trigger              <= '0;
      o_end_of_cycle_irq         <= '0;
      o_fault_event_irq          <= '0;
      o_divided_controller_clock <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rdata_d : REG_RST;
      o_pin_out <= pin_d;
      o_adc_trigger <= trig_d;
      o_end_of_cycle_irq <= irq_pend[IF_END_LSB +: NUM_MOD];
      o_fault_event_irq <= irq_pend[IF_EV_LSB +: NUM_MOD];
      o_divided_controller_clock <= div_tick_q;
    end
  end

endmodule

// *** pssci_monitor.sv ***
`timescale 1ns/1ns
module pssci_monitor
  import pssci_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [DATA_W-1:0]  i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  input  wire logic [DATA_W-1:0]  o_rdata,
  input  wire logic [NUM_MOD-1:0] o_end_of_cycle_irq,
  input  wire logic [NUM_MOD-1:0] o_fault_event_irq,
  input  wire logic               o_divided_controller_clock
);
  logic [DATA_W-1:0]  ctrl_q;
  logic [DATA_W-1:0]  mask_q;
  logic [DATA_W-1:0]  mask_p_q;
  logic [ROUTE_W-1:0] route_q;
  logic [ROUTE_W-1:0] trig_q;

  // ****************************************************************
  // mirror of software writes, kept from the bus alone
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q   <= 8'h00;
      mask_q   <= 8'h00;
      mask_p_q <= 8'h00;
      route_q  <= 6'h00;
      trig_q   <= 6'h00;
    end else begin
      mask_p_q <= mask_q;
      if (i_wr && i_addr == OFS_CTRL) ctrl_q <= i_wdata;
      if (i_wr && i_addr == OFS_IMASK) mask_q <= i_wdata;
      if (i_wr && i_addr == OFS_ROUTE) route_q <= i_wdata[5:0];
      if (i_wr && i_addr == OFS_TRIGSEL) trig_q <= i_wdata[5:0];
    end
  end

  // io source with divide by 4 or 32
  wire io4  = ctrl_q[7:5] == 3'b010;
  wire io32 = ctrl_q[7:5] == 3'b100;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_route_readback: assert property (
    $past(i_rd) && $past(i_addr) == OFS_ROUTE
    |-> o_rdata[5:0] == $past(route_q)) else $error("routing readback");
  chk_trig_readback: assert property (
    $past(i_rd) && $past(i_addr) == OFS_TRIGSEL
    |-> o_rdata[5:0] == $past(trig_q)) else $error("trigger readback");
  chk_ctrl_readback: assert property (
    $past(i_rd) && $past(i_addr) == OFS_CTRL
    |-> o_rdata == ($past(ctrl_q) & CTRL_MASK)) else $error("ctrl readback");
  chk_div1_pulses: assert property (
    o_divided_controller_clock && $past(ctrl_q[7:5], 2) == 3'b000
    |=> o_divided_controller_clock) else $error("undivided tick lost");
  chk_div4_gap: assert property (
    o_divided_controller_clock && io4 && $past(io4, 4)
    |=> !o_divided_controller_clock [*3]) else $error("div4 tick early");
  chk_div32_gap: assert property (
    o_divided_controller_clock && io32 && $past(io32, 8)
    |=> !o_divided_controller_clock [*8]) else $error("div32 tick early");
  chk_fault_masked: assert property (
    (o_fault_event_irq & ~(mask_q[2:0] | mask_p_q[2:0])) == 3'b000)
    else $error("fault irq while disabled");
  chk_end_masked: assert property (
    (o_end_of_cycle_irq & ~(mask_q[5:3] | mask_p_q[5:3])) == 3'b000)
    else $error("end irq while disabled");
endmodule

bind pssci_top pssci_monitor u_mon (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_end_of_cycle_irq(o_end_of_cycle_irq),
  .o_fault_event_irq(o_fault_event_irq),
  .o_divided_controller_clock(o_divided_controller_clock)
);

// *** pssci_partner.sv ***
`timescale 1ns/1ns
module pssci_partner
  import pssci_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic [NUM_MOD-1:0]    i_adc_trigger,
  input  wire logic [NUM_MOD-1:0]    i_fault_req,
  output logic                       o_pll_clk,
  output logic      [NUM_MOD-1:0]    o_fault_in,
  output logic [NUM_MOD-1:0][15:0]   o_trig_cnt,
  output logic [NUM_MOD-1:0][31:0]   o_trig_at
);
  logic [31:0] now_q;

  // pll runs free, phase unrelated to the reference clock
  initial begin
    o_pll_clk = 1'b0;
    #3;
    forever #20 o_pll_clk = ~o_pll_clk;
  end

  // switch fault pin raised on request of the bench
  assign o_fault_in = i_fault_req;

  // adc sampler: each trigger counted and time-stamped
  initial begin
    now_q      = 32'h0000_0000;
    o_trig_cnt = '0;
    o_trig_at  = '0;
  end
  always @(posedge i_ref_clk) begin
    now_q <= now_q + 32'h0000_0001;
    for (int m = 0; m < NUM_MOD; m++) begin
      if (i_adc_trigger[m] === 1'b1) begin
        o_trig_cnt[m] <= o_trig_cnt[m] + 16'h0001;
        o_trig_at[m]  <= now_q;
      end
    end
  end
endmodule

// *** pssci_top_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module pssci_top_tb
  import pssci_pkg::*;
;
  logic                     clk, resetn, wr, rd, div;
  logic [ADDR_W-1:0]        addr;
  logic [DATA_W-1:0]        wd, rdat;
  logic [NUM_MOD-1:0]       flt, freq, trig, eirq, firq, sync;
  logic [ROUTE_W-1:0]       port, pin;
  logic                     pll;
  logic [NUM_MOD-1:0][15:0] tcnt;
  logic [NUM_MOD-1:0][31:0] tat;
  int                       errors, checks;

  pssci_top dut (.i_ref_clk(clk), .i_resetn(resetn), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_pll_clk(pll),
    .i_fault_in(flt), .i_sync_error(sync), .i_port_out(port),
    .o_pin_out(pin), .o_adc_trigger(trig), .o_end_of_cycle_irq(eirq),
    .o_fault_event_irq(firq), .o_divided_controller_clock(div));
  pssci_partner far (.i_ref_clk(clk), .i_adc_trigger(trig),
    .i_fault_req(freq), .o_pll_clk(pll), .o_fault_in(flt),
    .o_trig_cnt(tcnt), .o_trig_at(tat));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // bus cycles and helpers
  // ****************************************************************
  task automatic bw(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask
  // waits, then lets the edge settle before looking
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [ADDR_W-1:0] ca(input int m, input int o);
    return OFS_CMP_BASE + 6'(CMP_STRIDE * m + o);
  endfunction
  // high byte first, the low byte commits both
  task automatic wcmp(input logic [ADDR_W-1:0] a, input logic [11:0] v);
    bw(a, {4'h0, v[11:8]});
    bw(a + 6'h01, v[7:0]);
  endtask
  task automatic pulses(output int k);
    k = 0;
    repeat (1024) begin
      cyc(1);
      if (div === 1'b1) k++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 40; a++) begin
      if (a < 4 || a > 15) begin
        br(a[5:0], d);
        `CHK(d, 8'h00)
      end
    end
    bw(6'h09, 8'hFF);
    br(6'h09, d);
    `CHK(d, 8'h00)
    `CHK(pin, port)
    $display("t_reset done");
  endtask
  task automatic t_cmp;
    logic [7:0] d;
    for (int m = 0; m < 3; m++) begin
      bw(ca(m, 0), 8'hF0 | 8'(m));
      bw(ca(m, 1), 8'h40 + 8'(m));
      br(ca(m, 0), d);
      `CHK(d, 8'(m))
      br(ca(m, 1), d);
      `CHK(d, 8'h40 + 8'(m))
    end
    // holder is shared: high byte of one, low byte of another
    bw(ca(0, 2), 8'h07);
    bw(ca(0, 5), 8'h11);
    br(ca(0, 4), d);
    `CHK(d, 8'h07)
    $display("t_cmp done");
  endtask
  task automatic t_clock;
    int k, e;
    int dv[4] = '{1, 4, 32, 256};
    for (int i = 0; i < 4; i++) begin
      bw(OFS_CTRL, {i[1:0], 6'h00});
      cyc(300);
      pulses(k);
      e = 1024 / dv[i];
      `CHK(k >= e - 1 && k <= e + 1, 1'b1)
    end
    bw(OFS_CTRL, 8'h20);
    cyc(300);
    pulses(k);
    `CHK(k >= 254 && k <= 258, 1'b1)
    bw(OFS_CTRL, 8'h00);
    $display("t_clock done");
  endtask
  task automatic t_trig;
    int off[4] = '{0, 3, 4, 7};
    int a0;
    for (int m = 0; m < 3; m++) begin
      wcmp(ca(m, 0), 12'h002);
      wcmp(ca(m, 2), 12'h005);
      wcmp(ca(m, 4), 12'h006);
      wcmp(ca(m, 6), 12'h009);
    end
    bw(OFS_CTRL, 8'h01);
    for (int c = 0; c < 4; c++) begin
      bw(OFS_TRIGSEL, {2'b00, c[1:0], 4'b0100});
      cyc(40);
      a0 = int'(tat[0]);
      `CHK((int'(tat[1]) - a0 + 100) % 10, 3)
      `CHK((int'(tat[2]) - a0 + 100) % 10, off[c])
    end
    $display("t_trig done");
  endtask
  task automatic t_centre;
    logic [15:0] c0, c1, c2;
    bw(OFS_CNF, 8'h10);
    for (int c = 2; c < 4; c++) begin
      bw(OFS_TRIGSEL, {2'b00, c[1:0], 4'b0100});
      cyc(30);
      c0 = tcnt[0];
      c1 = tcnt[1];
      c2 = tcnt[2];
      cyc(54);
      `CHK(tcnt[2], c2)
      `CHK(tcnt[0] - c0, 16'h0003)
      `CHK(tcnt[1] - c1, 16'h0003)
    end
    `CHK(tat[0] !== tat[1], 1'b1)
    bw(OFS_CNF, 8'h00);
    $display("t_centre done");
  endtask
  task automatic t_pins;
    int k, q;
    logic [7:0] d;
    @(posedge clk);
    port <= 6'h2A;
    bw(OFS_CNF, 8'h0C);
    bw(OFS_ROUTE, 8'h01);
    br(OFS_ROUTE, d);
    `CHK(d, 8'h01)
    cyc(40);
    k = 0;
    q = 0;
    repeat (100) begin
      cyc(1);
      if (pin[0] === 1'b1) k++;
      if (pin[5:1] !== port[5:1]) q++;
    end
    `CHK(k, 30)
    `CHK(q, 0)
    $display("t_pins done");
  endtask
  task automatic t_irq;
    logic [7:0] d;
    bw(OFS_IFLAG, 8'h3F);
    cyc(30);
    br(OFS_IFLAG, d);
    `CHK(d[5:3], 3'b111)
    `CHK(eirq, 3'b000)
    bw(OFS_IMASK, 8'h10);
    cyc(3);
    `CHK(eirq, 3'b010)
    bw(OFS_ICTL_BASE + 6'h01, 8'h01);
    @(posedge clk);
    freq <= 3'b010;
    cyc(10);
    br(OFS_IFLAG, d);
    `CHK(d[2:0], 3'b010)
    `CHK(firq, 3'b000)
    bw(OFS_IMASK, 8'h02);
    cyc(3);
    `CHK(firq, 3'b010)
    // level still active after clearing: no second event
    bw(OFS_IFLAG, 8'h02);
    cyc(3);
    br(OFS_IFLAG, d);
    `CHK(d[1], 1'b0)
    `CHK(firq, 3'b000)
    @(posedge clk);
    freq <= 3'b000;
    sync <= 3'b100;
    @(posedge clk);
    sync <= 3'b000;
    br(OFS_IFLAG, d);
    `CHK(d[2:0], 3'b100)
    $display("t_irq done");
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    {wr, rd, addr, wd, port, freq, sync} = '0;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_cmp;
    t_clock;
    t_trig;
    t_centre;
    t_pins;
    t_irq;
    wrap_up;
  end

  // watchdog, about seven times the expected run
  initial begin
    #500_000;
    errors++;
    wrap_up;
  end
endmodule
